// ---- verilog/acmp_defines.svh ----
`ifndef ACMP_DEFINES_SVH
`define ACMP_DEFINES_SVH

// Register byte addresses
`define ACMP_CTRL_ONE_ADDR  8'hac
`define ACMP_CTRL_TWO_ADDR  8'had
`define ACMP_IRQ_STAT_ADDR  8'hb0
`define ACMP_IRQ_CLR_ADDR   8'hb1
`define ACMP_IRQ_EN_ADDR    8'hb2

// Reset values
`define ACMP_CTRL_RESET     8'h00
`define ACMP_IRQ_EN_RESET   8'h00
`define ACMP_RDATA_IDLE     8'h00

// Control register field positions
`define ACMP_ON_BIT         5
`define ACMP_POS_BIT        4
`define ACMP_NEG_BIT        3
`define ACMP_DRIVE_BIT      2
`define ACMP_SYNCED_BIT     1
`define ACMP_FLAG_BIT       0

// Interrupt enable register field positions
`define ACMP_IEN_ONE_BIT    0
`define ACMP_IEN_TWO_BIT    1
`define ACMP_IEN_GLOBAL_BIT 7

// Settling time and clock rate
`define ACMP_SETTLE_US      10
`define ACMP_CLK_MHZ        100
`define ACMP_SETTLE_CYCLES  (`ACMP_SETTLE_US * `ACMP_CLK_MHZ)

// Number of comparators
`define ACMP_NUM_CMP        2

`endif

// ---- verilog/acmp_pkg.sv ----
package acmp_pkg;

    // Comparator control register layout
    typedef struct packed {
        logic [1:0] reserved;                // Always reads zero
        logic       comparator_on;           // Comparator enable
        logic       positive_input_select;   // Positive input choice
        logic       negative_input_select;   // 0 = external pin, 1 = internal reference
        logic       pin_drive_enable;        // Raw result to output pin
        logic       synced_result;           // Clock-synchronised result
        logic       result_change_flag;      // Sticky change flag
    } acmp_ctrl_s;

    // Settings sent to one analog core
    typedef struct packed {
        logic comparator_on;
        logic positive_input_select;
        logic negative_input_select;
    } acmp_core_cfg_s;

    // Bus access decode
    typedef enum logic [2:0] {
        ACMP_SEL_NONE,
        ACMP_SEL_CTRL_ONE,
        ACMP_SEL_CTRL_TWO,
        ACMP_SEL_IRQ_STAT,
        ACMP_SEL_IRQ_CLR,
        ACMP_SEL_IRQ_EN
    } acmp_sel_e;

endpackage

// ---- verilog/acmp_channel.sv ----
`timescale 1ns/1ps
`include "acmp_defines.svh"

module acmp_channel
    import acmp_pkg::*;
#(
    parameter int SETTLE_CYCLES = `ACMP_SETTLE_CYCLES,
    localparam int CW = $clog2(SETTLE_CYCLES + 1)
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // Control from register file
    input  wire logic enable_i,
    // Asynchronous result from the analog core
    input  wire logic raw_i,
    // Status to register file
    output logic      synced_o,
    output logic      change_o,
    output logic      settled_o
);

    logic          sync1_ff;       // First synchroniser stage, read only by sync2_ff
    logic          sync2_ff;       // Second synchroniser stage
    logic          synced_ff;      // Result as software sees it
    logic          change_ff;      // One-cycle change pulse
    logic [CW-1:0] settle_cnt_ff;  // Cycles since enable
    logic          settled_ff;     // Settling window over
    logic          nxt_synced;     // Next synced value

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchroniser on the raw result
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end else begin
            sync1_ff <= raw_i;
            sync2_ff <= sync1_ff;
        end
    end

    // Forced low while the comparator is off
    assign nxt_synced = enable_i & sync2_ff;

    // Synced result register
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            synced_ff <= 1'b0;
        end else begin
            synced_ff <= nxt_synced;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Settling counter, restarted on every enable; the core output is junk meanwhile
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            settle_cnt_ff <= '0;
            settled_ff    <= 1'b0;
        end else if (!enable_i) begin
            // Off: rearm for the next enable
            settle_cnt_ff <= '0;
            settled_ff    <= 1'b0;
        end else if (!settled_ff) begin
            settle_cnt_ff <= CW'(settle_cnt_ff + 1'b1);
            settled_ff    <= (settle_cnt_ff == CW'(SETTLE_CYCLES - 1));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Change pulse in either direction, only once settled so that start-up
    // glitches do not leave a stale flag behind
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            change_ff <= 1'b0;
        end else begin
            change_ff <= enable_i & settled_ff & (nxt_synced != synced_ff);
        end
    end

    assign synced_o  = synced_ff;
    assign change_o  = change_ff;
    assign settled_o = settled_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sync_latency_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (enable_i && $past(enable_i) && $past(enable_i, 2)) |-> synced_ff == $past(raw_i, 3))
        else $error("synced result does not follow raw input after three edges");

    off_forces_zero_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !$past(enable_i) |-> !synced_ff)
        else $error("synced result not zero while disabled");

    settle_count_a: assert property (@(posedge clock_i) disable iff (rst_i)
        $rose(settled_ff) |-> $past(settle_cnt_ff) == CW'(SETTLE_CYCLES - 1))
        else $error("settling window has wrong length");

    change_edge_a: assert property (@(posedge clock_i) disable iff (rst_i)
        ($past(enable_i) && $past(settled_ff) && $changed(synced_ff)) |-> change_ff)
        else $error("change of synced result not reported");

endmodule // acmp_channel

// ---- verilog/acmp_ctrl.sv ----
`timescale 1ns/1ps
`include "acmp_defines.svh"

module acmp_ctrl
    import acmp_pkg::*;
#(
    parameter int NUM_CMP       = `ACMP_NUM_CMP,
    parameter int SETTLE_CYCLES = `ACMP_SETTLE_CYCLES
) (
    // Clock and reset
    input  wire logic               clock_i,
    input  wire logic               rst_i,
    // Register port
    input  wire logic [7:0]         addr_i,
    input  wire logic [7:0]         wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    output logic      [7:0]         rdata_o,
    // Analog core side
    input  wire logic [NUM_CMP-1:0] raw_result_i,
    output acmp_core_cfg_s [NUM_CMP-1:0] core_cfg_o,
    // Comparator output pins
    output logic      [NUM_CMP-1:0] cmp_pin_out_o,
    output logic      [NUM_CMP-1:0] cmp_pin_oe_o,
    // Status and interrupt
    output logic      [NUM_CMP-1:0] settled_o,
    output logic                    irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    acmp_ctrl_s [NUM_CMP-1:0] ctrl_ff;        // Control registers
    logic       [NUM_CMP-1:0] irq_en_ff;      // Per-comparator interrupt enables
    logic                     global_en_ff;   // Global interrupt enable
    logic                     irq_ff;         // Registered interrupt line
    logic       [7:0]         rdata_ff;       // Read data, valid one cycle
    logic       [NUM_CMP-1:0] synced;         // Synced results from channels
    logic       [NUM_CMP-1:0] change;         // Change pulses from channels
    logic       [NUM_CMP-1:0] settled;        // Settling done per channel
    logic       [NUM_CMP-1:0] flags;          // Flag vector view
    logic       [NUM_CMP-1:0] nxt_flags;      // Next flag values
    logic       [NUM_CMP-1:0] ctrl_wr;        // Write strobe per control register
    logic       [7:0]         nxt_rdata;      // Read mux output
    acmp_sel_e                sel;            // Decoded address

    ////////////////////////////////////////////////////////////////////////////
    // Address decode, shared by reads and writes
    always_comb begin
        unique case (addr_i)
            `ACMP_CTRL_ONE_ADDR: sel = ACMP_SEL_CTRL_ONE;
            `ACMP_CTRL_TWO_ADDR: sel = ACMP_SEL_CTRL_TWO;
            `ACMP_IRQ_STAT_ADDR: sel = ACMP_SEL_IRQ_STAT;
            `ACMP_IRQ_CLR_ADDR:  sel = ACMP_SEL_IRQ_CLR;
            `ACMP_IRQ_EN_ADDR:   sel = ACMP_SEL_IRQ_EN;
            default:             sel = ACMP_SEL_NONE;   // Unmapped
        endcase
    end

    // Control register write strobes
    assign ctrl_wr[0] = wr_i & (sel == ACMP_SEL_CTRL_ONE);
    assign ctrl_wr[1] = wr_i & (sel == ACMP_SEL_CTRL_TWO);

    ////////////////////////////////////////////////////////////////////////////
    // Comparator channels: synchroniser, settling timer, change detect
    generate
        for (genvar gi = 0; gi < NUM_CMP; gi++) begin : g_chan
            acmp_channel #(
                .SETTLE_CYCLES (SETTLE_CYCLES)
            ) u_chan (
                .clock_i   (clock_i),
                .rst_i     (rst_i),
                .enable_i  (ctrl_ff[gi].comparator_on),
                .raw_i     (raw_result_i[gi]),
                .synced_o  (synced[gi]),
                .change_o  (change[gi]),
                .settled_o (settled[gi])
            );
            assign flags[gi] = ctrl_ff[gi].result_change_flag;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Next flag value: software write via control byte or clear register,
    // hardware set applied last so it always wins
    always_comb begin
        nxt_flags = flags;
        for (int i = 0; i < NUM_CMP; i++) begin
            // Control byte write stores bit 0 as given
            if (ctrl_wr[i]) begin
                nxt_flags[i] = wdata_i[`ACMP_FLAG_BIT];
            end
            // Write-one-to-clear register
            if (wr_i && sel == ACMP_SEL_IRQ_CLR && wdata_i[i]) begin
                nxt_flags[i] = 1'b0;
            end
            // Hardware change; never cleared automatically
            if (change[i]) begin
                nxt_flags[i] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers; reserved bits are not stored and read as zero
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_ff <= {NUM_CMP{`ACMP_CTRL_RESET}};
        end else begin
            for (int i = 0; i < NUM_CMP; i++) begin
                if (ctrl_wr[i]) begin
                    ctrl_ff[i].comparator_on         <= wdata_i[`ACMP_ON_BIT];
                    ctrl_ff[i].positive_input_select <= wdata_i[`ACMP_POS_BIT];
                    ctrl_ff[i].negative_input_select <= wdata_i[`ACMP_NEG_BIT];
                    ctrl_ff[i].pin_drive_enable      <= wdata_i[`ACMP_DRIVE_BIT];
                end
                ctrl_ff[i].reserved           <= 2'b00;
                ctrl_ff[i].synced_result      <= synced[i];
                ctrl_ff[i].result_change_flag <= nxt_flags[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt enable register
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            irq_en_ff    <= '0;
            global_en_ff <= 1'b0;
        end else if (wr_i && sel == ACMP_SEL_IRQ_EN) begin
            irq_en_ff[0] <= wdata_i[`ACMP_IEN_ONE_BIT];
            irq_en_ff[1] <= wdata_i[`ACMP_IEN_TWO_BIT];
            global_en_ff <= wdata_i[`ACMP_IEN_GLOBAL_BIT];
        end
    end

    // Level interrupt; priority arbitration is left to the interrupt controller
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= global_en_ff & |(irq_en_ff & flags);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb begin
        nxt_rdata = `ACMP_RDATA_IDLE;
        unique case (sel)
            ACMP_SEL_CTRL_ONE: nxt_rdata = ctrl_ff[0];
            ACMP_SEL_CTRL_TWO: nxt_rdata = ctrl_ff[1];
            ACMP_SEL_IRQ_STAT: nxt_rdata = {6'h00, flags};
            ACMP_SEL_IRQ_EN: begin
                nxt_rdata[`ACMP_IEN_ONE_BIT]    = irq_en_ff[0];
                nxt_rdata[`ACMP_IEN_TWO_BIT]    = irq_en_ff[1];
                nxt_rdata[`ACMP_IEN_GLOBAL_BIT] = global_en_ff;
            end
            ACMP_SEL_IRQ_CLR:  nxt_rdata = `ACMP_RDATA_IDLE; // Write-only
            ACMP_SEL_NONE:     nxt_rdata = `ACMP_RDATA_IDLE; // Unmapped reads zero
        endcase
    end

    // Read data live only in the cycle after the strobe
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_ff <= `ACMP_RDATA_IDLE;
        end else begin
            rdata_ff <= rd_i ? nxt_rdata : `ACMP_RDATA_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs. The pin path is deliberately combinational from the raw core
    // result: it must switch without waiting for a clock edge.
    always_comb begin
        for (int i = 0; i < NUM_CMP; i++) begin
            core_cfg_o[i].comparator_on         = ctrl_ff[i].comparator_on;
            core_cfg_o[i].positive_input_select = ctrl_ff[i].positive_input_select;
            core_cfg_o[i].negative_input_select = ctrl_ff[i].negative_input_select;
            cmp_pin_oe_o[i]  = ctrl_ff[i].comparator_on & ctrl_ff[i].pin_drive_enable;
            cmp_pin_out_o[i] = cmp_pin_oe_o[i] & raw_result_i[i];
        end
    end

    assign rdata_o   = rdata_ff;
    assign irq_o     = irq_ff;
    assign settled_o = settled;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    set_beats_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
        change[0] |=> ctrl_ff[0].result_change_flag)
        else $error("hardware set lost against software clear");

    flag_sticky_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (flags[0] && !wr_i) |=> flags[0])
        else $error("change flag cleared without a write");

    irq_gate_a: assert property (@(posedge clock_i) disable iff (rst_i)
        irq_ff |-> $past(global_en_ff) && ($past(irq_en_ff) & $past(flags)) != '0)
        else $error("interrupt raised without both enables and a flag");

    irq_raise_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (global_en_ff && irq_en_ff[1] && flags[1]) |=> irq_ff)
        else $error("enabled flag did not raise interrupt");

    ctrl_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
        ctrl_wr[1] |=> ctrl_ff[1].comparator_on == $past(wdata_i[`ACMP_ON_BIT])
                    && ctrl_ff[1].pin_drive_enable == $past(wdata_i[`ACMP_DRIVE_BIT]))
        else $error("control byte write not stored");

    read_window_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !rd_i |=> rdata_ff == `ACMP_RDATA_IDLE)
        else $error("read data present outside read cycle");

    reserved_zero_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (rd_i && sel == ACMP_SEL_CTRL_ONE) |=> rdata_ff[7:6] == 2'b00)
        else $error("reserved bits read nonzero");

    pin_drive_a: assert property (@(posedge clock_i) disable iff (rst_i)
        cmp_pin_oe_o[0] == (ctrl_ff[0].comparator_on && ctrl_ff[0].pin_drive_enable))
        else $error("pin drive enable wrong");

    synced_off_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (!ctrl_ff[0].comparator_on && !$past(ctrl_ff[0].comparator_on, 2)) |-> !ctrl_ff[0].synced_result)
        else $error("synced result set while disabled");

    // Main scenarios
    flag_set_c:     cover property (@(posedge clock_i) disable iff (rst_i) change[0] ##1 flags[0]);
    irq_fire_c:     cover property (@(posedge clock_i) disable iff (rst_i) $rose(irq_ff));
    set_and_clr_c:  cover property (@(posedge clock_i) disable iff (rst_i)
        change[1] && wr_i && sel == ACMP_SEL_IRQ_CLR && wdata_i[1]);
    settle_done_c:  cover property (@(posedge clock_i) disable iff (rst_i) $rose(settled[0]));

endmodule // acmp_ctrl

// ---- dv/acmp_core_model.sv ----
`timescale 1ns/1ps

module acmp_core_model
    import acmp_pkg::*;
#(
    parameter int INT_REF_MV = 1280                 // Internal reference level in mV
) (
    // Clock and reset
    input  wire logic                clock_i,
    input  wire logic                rst_i,
    // Core settings from the block
    input  wire acmp_core_cfg_s [1:0] core_cfg_i,
    // Analog levels in mV, one lane per comparator
    input  wire logic [1:0][15:0]    pos_a_mv_i,
    input  wire logic [1:0][15:0]    pos_b_mv_i,
    input  wire logic [1:0][15:0]    ext_ref_mv_i,
    // Raw results towards the block
    output logic      [1:0]          raw_result_o
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [1:0] junk_ff;                            // Level seen from an unpowered core

    // A core that is off gives no stable level, so toggle it every cycle
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            junk_ff <= 2'b01;
        end else begin
            junk_ff <= ~junk_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Input muxes and the comparison itself; no clock on this path
    for (genvar n = 0; n < 2; n++) begin : g_core
        logic [15:0] pos_mv;                        // Selected positive level
        logic [15:0] neg_mv;                        // Selected negative level
        assign pos_mv = core_cfg_i[n].positive_input_select ? pos_b_mv_i[n] : pos_a_mv_i[n];
        assign neg_mv = core_cfg_i[n].negative_input_select ? 16'(INT_REF_MV) : ext_ref_mv_i[n];
        assign raw_result_o[n] = core_cfg_i[n].comparator_on ? (pos_mv > neg_mv) : junk_ff[n];
    end

endmodule // acmp_core_model

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps

module tb_top
    import acmp_pkg::*;
;
    localparam int SETTLE = 4;                      // Short settling window for the run
    typedef struct packed {
        logic [2:0] cfg;                            // Positive, negative, pin drive
        logic       res;                            // Expected result
    } acmp_row_s;

    ////////////////////////////////////////////////////////////////////////////////
    logic                 clock_i = 1'b0;           // Bench clock
    logic                 rst_i   = 1'b1;           // Reset, held at start
    logic [7:0]           addr_i  = 8'h00;          // Register port
    logic [7:0]           wdata_i = 8'h00;
    logic                 wr_i    = 1'b0;
    logic                 rd_i    = 1'b0;
    logic [7:0]           rdata_o;
    logic [1:0]           raw;                      // Model to block
    acmp_core_cfg_s [1:0] core_cfg;                 // Block to model
    logic [1:0]           pin_out;
    logic [1:0]           pin_oe;
    logic [1:0]           settled;
    logic                 irq;
    logic [1:0][15:0]     pos_a   = {16'h05dc, 16'h05dc}; // 1500 mV
    logic [1:0][15:0]     pos_b   = {16'h0514, 16'h0514}; // 1300 mV
    logic [1:0][15:0]     ext_ref = {16'h0578, 16'h0578}; // 1400 mV
    int                   errors = 0;
    int                   num_checks = 0;
    logic [7:0]           d;                        // Last read value
    logic [7:0]           base;                     // Control byte address
    // Levels above give a low result only for positive input B against the external reference
    acmp_row_s            rows [8] = '{'{3'b000, 1'b1}, '{3'b001, 1'b1}, '{3'b010, 1'b1}, '{3'b011, 1'b1},
                                       '{3'b100, 1'b0}, '{3'b101, 1'b0}, '{3'b110, 1'b1}, '{3'b111, 1'b1}};

    always #5 clock_i = ~clock_i;

    acmp_ctrl #(.NUM_CMP(2), .SETTLE_CYCLES(SETTLE)) u_dut (
        .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .raw_result_i(raw), .core_cfg_o(core_cfg), .cmp_pin_out_o(pin_out),
        .cmp_pin_oe_o(pin_oe), .settled_o(settled), .irq_o(irq));

    acmp_core_model u_cores (
        .clock_i(clock_i), .rst_i(rst_i), .core_cfg_i(core_cfg), .pos_a_mv_i(pos_a), .pos_b_mv_i(pos_b),
        .ext_ref_mv_i(ext_ref), .raw_result_o(raw));

    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle write strobe
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i   <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        #100000;
        errors++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        // Reset values and unmapped space
        reg_rd(8'hac);
        check("ctrl one reset", d, 8'h00);
        reg_rd(8'had);
        check("ctrl two reset", d, 8'h00);
        reg_wr(8'hae, 8'hff);
        reg_rd(8'hae);
        check("unmapped read", d, 8'h00);
        check("irq after reset", {7'h0, irq}, 8'h00);
        $display("test reset done");
        // Every configuration on both comparators
        for (int n = 0; n < 2; n++) begin
            base = n[0] ? 8'had : 8'hac;
            for (int r = 0; r < 8; r++) begin
                reg_wr(base, {3'b001, rows[r].cfg, 2'b00});
                wait_cyc(SETTLE + 8);
                reg_rd(base);
                check("ctrl byte", d & 8'hfe, {3'b001, rows[r].cfg, rows[r].res, 1'b0});
                check("core cfg", {5'h0, core_cfg[n]}, {5'h01, rows[r].cfg[2:1]});
                check("pin oe", {7'h0, pin_oe[n]}, {7'h0, rows[r].cfg[0]});
                check("pin out", {7'h0, pin_out[n]}, {7'h0, rows[r].res & rows[r].cfg[0]});
            end
        end
        $display("test configurations done");
        // Switching off forces the synced bit low without a flag
        reg_wr(8'hb1, 8'h03);
        reg_wr(8'hac, 8'h00);
        wait_cyc(8);
        reg_rd(8'hac);
        check("off byte", d, 8'h00);
        reg_rd(8'hb0);
        check("no flag on disable", d, 8'h00);
        check("pin oe off", {7'h0, pin_oe[0]}, 8'h00);
        $display("test disable done");
        // Settling, then flags in both directions and the interrupt
        reg_wr(8'hac, 8'h24);
        #1;
        check("settled early", {7'h0, settled[0]}, 8'h00);
        wait_cyc(SETTLE + 8);
        check("settled late", {7'h0, settled[0]}, 8'h01);
        reg_wr(8'hb1, 8'h01);
        reg_wr(8'hb2, 8'h81);
        wait_cyc(2);
        check("irq idle", {7'h0, irq}, 8'h00);
        @(posedge clock_i);
        pos_a[0] <= 16'h0514;
        #1;
        check("pin follows raw", {7'h0, pin_out[0]}, 8'h00);
        wait_cyc(8);
        check("irq on fall", {7'h0, irq}, 8'h01);
        reg_rd(8'hac);
        check("flag on fall", d, 8'h25);
        wait_cyc(20);
        check("irq sticky", {7'h0, irq}, 8'h01);
        reg_wr(8'hb1, 8'h01);
        wait_cyc(2);
        check("irq cleared", {7'h0, irq}, 8'h00);
        @(posedge clock_i);
        pos_a[0] <= 16'h05dc;
        wait_cyc(8);
        reg_rd(8'hac);
        check("flag on rise", d, 8'h27);
        reg_wr(8'hac, 8'h24);
        wait_cyc(2);
        check("irq bit clear", {7'h0, irq}, 8'h00);
        reg_rd(8'hac);
        check("flag bit clear", d, 8'h26);
        $display("test flags done");
        // Global and individual interrupt enables
        reg_wr(8'hb2, 8'h01);
        @(posedge clock_i);
        pos_a[0] <= 16'h0514;
        wait_cyc(8);
        check("irq global off", {7'h0, irq}, 8'h00);
        reg_rd(8'hb0);
        check("status", d, 8'h01);
        reg_wr(8'hb2, 8'h81);
        wait_cyc(2);
        check("irq global on", {7'h0, irq}, 8'h01);
        reg_wr(8'hb2, 8'h80);
        wait_cyc(2);
        check("irq own off", {7'h0, irq}, 8'h00);
        reg_rd(8'hb2);
        check("enable read", d, 8'h80);
        reg_rd(8'hb1);
        check("clear reads zero", d, 8'h00);
        // Clear lands on the very edge that sees the change pulse
        reg_wr(8'hb1, 8'h01);
        @(posedge clock_i);
        pos_a[0] <= 16'h05dc;
        repeat (2) @(posedge clock_i);
        reg_wr(8'hb1, 8'h01);
        reg_rd(8'hac);
        check("set beats clear", d, 8'h27);
        $display("test enables done");
        wrap_up();
    end

endmodule // tb_top
